// ===== design/ood_decode.sv
// Operand-field decoder for an 8-bit core, with AHB-Lite access
`timescale 1ns/100ps
// Functional notes
// - Access bit 0 uses access region, 1 uses bank
// - Destination bit 0 to accumulator, 1 to file
// - Short file address is eight bits
// - Move carries twelve-bit source file address
// - Move carries twelve-bit destination file address
// - Three-bit index selects bit zero to seven
// - Table mode: hold, post-inc, post-dec, pre-inc
// - Table pointer 21 bits, eight-bit table latch
// - Fast bit one uses shadow registers
// - Branch offset signed; call has a direct address
// - Literals are 8, 12 or 20 bits
// - Don't-care bits never influence decode
// - Five status flags kept for instructions
// - Bit clear is 1001 bbba ffff ffff
module ood_decode
   import ood_pkg::*;
(
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   // AHB-Lite slave
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   // Decoded execute-stage outputs
   output logic [11:0] FILE_ADDR_O,
   output logic DEST_FILE_O,
   output logic [7:0] BIT_MASK_O,
   output logic SHADOW_USE_O,
   output logic [20:0] TABLE_POINTER_O
);
   // ------------------------------------------------------------
   // Bus address phase capture
   // ------------------------------------------------------------
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic [15:0] instr_r;
   logic [15:0] instr2_r;
   logic [3:0] bank_select_reg_r;
   logic [20:0] table_pointer_r;
   logic [7:0] table_latch_r;
   logic [4:0] flags_r;
   logic [31:0] rdata_nxt;
   logic acc_ph;

   assign acc_ph = HSEL_I && HREADY_I && HTRANS_I[1];

   always_ff @(posedge CLK_I)
   begin
      if (!RESET_N_I)
      begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end
      else
      begin
         wr_pend_r <= acc_ph && HWRITE_I;
         wr_addr_r <= HADDR_I[7:0];
      end
   end

   // ------------------------------------------------------------
   // Field extraction, purely combinational
   // ------------------------------------------------------------
   logic access_sel;
   logic dest_sel;
   logic [7:0] short_faddr;
   logic [2:0] bit_index;
   logic [11:0] source_file_address;
   logic [11:0] destination_file_address;
   logic [3:0] eff_bank;
   logic is_bit_clear;
   logic is_move;
   logic is_branch_neg;
   logic is_rel_bra;
   logic is_call;
   logic is_return;
   logic is_table;
   logic is_lit8;
   logic is_lfsr;
   logic fast_sel;
   ood_tpm_e table_pointer_mode;
   logic [20:0] branch_target;
   logic [19:0] literal;
   logic [1:0] lit_width;

   assign access_sel = instr_r[ACC_BIT];
   assign dest_sel = instr_r[DEST_BIT];
   assign short_faddr = instr_r[7:0];
   assign bit_index = instr_r[BIT_LSB +: 3];
   assign source_file_address = instr_r[11:0];
   assign destination_file_address = instr2_r[11:0];
   assign eff_bank = access_sel ? bank_select_reg_r : ACCESS_BANK;
   assign is_bit_clear = instr_r[15:12] == OPC_BIT_CLEAR;
   assign is_move = instr_r[15:12] == OPC_MOVE;
   assign is_branch_neg = instr_r[15:8] == OPC_BRANCH_NEG;
   assign is_rel_bra = instr_r[15:11] == OPC_REL_BRA;
   assign is_call = instr_r[15:9] == OPC_CALL[7:1];
   assign is_return = instr_r[15:1] == OPC_RETURN[15:1];
   assign is_table = instr_r[15:2] == OPC_TABLE;
   assign is_lit8 = instr_r[15:8] == OPC_LIT8;
   assign is_lfsr = instr_r[15:8] == OPC_LFSR;
   assign table_pointer_mode = ood_tpm_e'(instr_r[1:0]);
   // Return keeps its fast bit in bit 0, call in bit 8
   assign fast_sel = is_return ? instr_r[FAST_BIT] : instr_r[8];

   // Upper bits of the call target come from the second word
   always_comb
   begin
      branch_target = TPTR_RESET;
      if (is_call)
         branch_target = {instr2_r[11:0], instr_r[7:0], 1'b0};
      else if (is_rel_bra)
         branch_target = {{10{instr_r[10]}}, instr_r[10:0]};
      else if (is_branch_neg)
         branch_target = {{13{instr_r[7]}}, instr_r[7:0]};
   end

   always_comb
   begin
      literal = 20'h0_0000;
      lit_width = 2'd0;
      if (is_lfsr)
      begin
         // Only bits used by the encoding feed the constant
         literal = {8'h00, instr_r[3:0], instr2_r[7:0]};
         lit_width = 2'd1;
      end
      else if (is_call)
      begin
         literal = {instr2_r[11:0], instr_r[7:0]};
         lit_width = 2'd2;
      end
      else if (is_lit8)
         literal = {12'h000, instr_r[7:0]};
   end

   // ------------------------------------------------------------
   // Registers written by software and by table accesses
   // ------------------------------------------------------------
   logic tbl_go;
   assign tbl_go = wr_pend_r && wr_addr_r == ADDR_TABLE && HWDATA_I[31];

   always_ff @(posedge CLK_I)
   begin
      if (!RESET_N_I)
      begin
         instr_r <= 16'h0000;
         instr2_r <= 16'h0000;
         bank_select_reg_r <= BANK_RESET;
         flags_r <= 5'h00;
      end
      else if (wr_pend_r)
      begin
         case (wr_addr_r)
            ADDR_INSTR: instr_r <= HWDATA_I[15:0];
            ADDR_INSTR2: instr2_r <= HWDATA_I[15:0];
            ADDR_BANK: bank_select_reg_r <= HWDATA_I[3:0];
            ADDR_STATUS: flags_r <= HWDATA_I[4:0];
            default: ;
         endcase
      end
   end

   // Table step with the decoded mode takes priority over a pointer write
   always_ff @(posedge CLK_I)
   begin
      if (!RESET_N_I)
      begin
         table_pointer_r <= TPTR_RESET;
         table_latch_r <= 8'h00;
      end
      else if (tbl_go && is_table)
      begin
         table_latch_r <= HWDATA_I[7:0];
         case (table_pointer_mode)
            TPM_POSTINC, TPM_PREINC: table_pointer_r <= table_pointer_r + 21'd1;
            TPM_POSTDEC: table_pointer_r <= table_pointer_r - 21'd1;
            default: table_pointer_r <= table_pointer_r;
         endcase
      end
      else if (wr_pend_r && wr_addr_r == ADDR_TABLE)
      begin
         table_pointer_r <= HWDATA_I[20:0];
      end
   end

   // ------------------------------------------------------------
   // Execute-stage outputs, registered
   // ------------------------------------------------------------
   always_ff @(posedge CLK_I)
   begin
      if (!RESET_N_I)
      begin
         FILE_ADDR_O <= 12'h000;
         DEST_FILE_O <= 1'b0;
         BIT_MASK_O <= 8'h00;
         SHADOW_USE_O <= 1'b0;
         TABLE_POINTER_O <= TPTR_RESET;
      end
      else
      begin
         FILE_ADDR_O <= is_move ? source_file_address : {eff_bank, short_faddr};
         DEST_FILE_O <= dest_sel;
         BIT_MASK_O <= is_bit_clear ? 8'(8'h01 << bit_index) : 8'h00;
         SHADOW_USE_O <= (is_call || is_return) && fast_sel;
         TABLE_POINTER_O <= table_pointer_r;
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   always_comb
   begin
      case (HADDR_I[7:0])
         ADDR_INSTR: rdata_nxt = {16'h0000, instr_r};
         ADDR_INSTR2: rdata_nxt = {16'h0000, instr2_r};
         ADDR_BANK: rdata_nxt = {28'h000_0000, bank_select_reg_r};
         ADDR_FIELDS: rdata_nxt = {16'h0000, is_bit_clear, fast_sel, table_pointer_mode,
            bit_index, access_sel, dest_sel, 7'h00};
         ADDR_FADDR: rdata_nxt = {20'h0_0000, eff_bank, short_faddr};
         ADDR_MOVE: rdata_nxt = {4'h0, destination_file_address, 4'h0,
            source_file_address};
         ADDR_LIT: rdata_nxt = {10'h000, lit_width, literal};
         ADDR_BRANCH: rdata_nxt = {11'h000, branch_target};
         ADDR_TABLE: rdata_nxt = {table_latch_r, 3'h0, table_pointer_r};
         ADDR_STATUS: rdata_nxt = {27'h000_0000, flags_r};
         default: rdata_nxt = RD_ZERO;
      endcase
   end

   always_ff @(posedge CLK_I)
   begin
      if (!RESET_N_I)
      begin
         HRDATA_O <= RD_ZERO;
         HREADYOUT_O <= 1'b1;
         HRESP_O <= 1'b0;
      end
      else
      begin
         HRDATA_O <= (acc_ph && !HWRITE_I) ? rdata_nxt : RD_ZERO;
         HREADYOUT_O <= 1'b1;
         HRESP_O <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   access_bank_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      !is_move && !access_sel |=> FILE_ADDR_O[11:8] == ACCESS_BANK)
      else $error("access region not used");
   bank_sel_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      !is_move && access_sel |=> FILE_ADDR_O[11:8] == $past(bank_select_reg_r))
      else $error("bank not taken");
   dest_sel_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      1'b1 |=> DEST_FILE_O == $past(instr_r[9]))
      else $error("destination wrong");
   short_addr_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      !is_move |=> FILE_ADDR_O[7:0] == $past(instr_r[7:0]))
      else $error("short address wrong");
   move_src_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      is_move |=> FILE_ADDR_O == $past(instr_r[11:0]))
      else $error("move source wrong");
   move_dest_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      acc_ph && !HWRITE_I && HADDR_I[7:0] == ADDR_MOVE
      |=> HRDATA_O[27:16] == $past(instr2_r[11:0]))
      else $error("move destination wrong");
   bit_mask_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      is_bit_clear |=> $onehot(BIT_MASK_O) && BIT_MASK_O[$past(instr_r[11:9])])
      else $error("bit index wrong");
   mask_off_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      !is_bit_clear |=> BIT_MASK_O == 8'h00)
      else $error("mask set outside bit clear");
   table_step_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      tbl_go && is_table && instr_r[1:0] == 2'b10
      |=> table_pointer_r == 21'($past(table_pointer_r) - 21'd1))
      else $error("post-decrement wrong");
   table_inc_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      tbl_go && is_table && instr_r[0]
      |=> table_pointer_r == 21'($past(table_pointer_r) + 21'd1))
      else $error("increment mode wrong");
   table_hold_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      tbl_go && is_table && instr_r[1:0] == 2'b00 |=> $stable(table_pointer_r))
      else $error("hold mode moved pointer");
   table_latch_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      tbl_go && is_table |=> table_latch_r == $past(HWDATA_I[7:0]))
      else $error("table latch not loaded");
   tptr_load_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      wr_pend_r && wr_addr_r == ADDR_TABLE && !HWDATA_I[31]
      |=> table_pointer_r == $past(HWDATA_I[20:0]))
      else $error("table pointer not loaded");
   shadow_use_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      is_return && !instr_r[0] |=> !SHADOW_USE_O)
      else $error("shadow used when not fast");
   shadow_call_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      is_call |=> SHADOW_USE_O == $past(instr_r[8]))
      else $error("call fast bit ignored");
   rel_sign_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      is_branch_neg |-> branch_target[20] == instr_r[7])
      else $error("offset not sign extended");
   rel_bra_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      is_rel_bra |-> branch_target[20:10] == {11{instr_r[10]}})
      else $error("long offset not sign extended");
   call_target_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      is_call |-> branch_target == {instr2_r[11:0], instr_r[7:0], 1'b0})
      else $error("call target wrong");
   lit8_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      is_lit8 |-> literal[19:8] == 12'h000)
      else $error("literal width wrong");
   call_lit_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      is_call |-> lit_width == 2'd2)
      else $error("call literal not wide");
   lfsr_lit_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      is_lfsr |-> lit_width == 2'd1 && literal[19:12] == 8'h00)
      else $error("twelve-bit literal wrong");
   flags_write_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      wr_pend_r && wr_addr_r == ADDR_STATUS |=> flags_r == $past(HWDATA_I[4:0]))
      else $error("status flags not written");
   fields_read_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      acc_ph && !HWRITE_I && HADDR_I[7:0] == ADDR_FIELDS
      |=> HRDATA_O[11:9] == $past(instr_r[11:9]))
      else $error("fields not current");
   ready_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      HREADYOUT_O && !HRESP_O)
      else $error("bus not ready");

   bit_clear_c: cover property (@(posedge CLK_I) disable iff (!RESET_N_I) is_bit_clear);
   table_c: cover property (@(posedge CLK_I) disable iff (!RESET_N_I) tbl_go && is_table);
   fast_c: cover property (@(posedge CLK_I) disable iff (!RESET_N_I) is_call && fast_sel);
   move_c: cover property (@(posedge CLK_I) disable iff (!RESET_N_I) is_move);
   branch_c: cover property (@(posedge CLK_I) disable iff (!RESET_N_I) is_branch_neg);
endmodule // ood_decode

// ===== design/ood_pkg.sv
// Constants for the operand-field decoder
package ood_pkg;
   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_INSTR = 8'h00;
   localparam logic [7:0] ADDR_INSTR2 = 8'h04;
   localparam logic [7:0] ADDR_BANK = 8'h08;
   localparam logic [7:0] ADDR_FIELDS = 8'h0C;
   localparam logic [7:0] ADDR_FADDR = 8'h10;
   localparam logic [7:0] ADDR_MOVE = 8'h14;
   localparam logic [7:0] ADDR_LIT = 8'h18;
   localparam logic [7:0] ADDR_BRANCH = 8'h1C;
   localparam logic [7:0] ADDR_TABLE = 8'h20;
   localparam logic [7:0] ADDR_STATUS = 8'h24;
   // ------------------------------------------------------------
   // Field positions and opcodes in the instruction word, and reset values
   // ------------------------------------------------------------
   localparam int ACC_BIT = 8;
   localparam int DEST_BIT = 9;
   localparam int BIT_LSB = 9;
   localparam int FAST_BIT = 0;
   localparam logic [3:0] OPC_BIT_CLEAR = 4'h9;
   localparam logic [7:0] OPC_BRANCH_NEG = 8'hE6;
   localparam logic [3:0] OPC_MOVE = 4'hC;
   localparam logic [3:0] OPC_SECOND = 4'hF;
   localparam logic [4:0] OPC_REL_BRA = 5'h1A;
   localparam logic [7:0] OPC_CALL = 8'hEC;
   localparam logic [15:0] OPC_RETURN = 16'h0012;
   localparam logic [13:0] OPC_TABLE = 14'h0002;
   localparam logic [7:0] OPC_LIT8 = 8'h0E;
   localparam logic [7:0] OPC_LFSR = 8'hEE;
   localparam logic [3:0] ACCESS_BANK = 4'h0;
   localparam logic [3:0] BANK_RESET = 4'h0;
   localparam logic [20:0] TPTR_RESET = 21'h00_0000;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;
   // Flag positions in the status word
   localparam int FLG_C = 0;
   localparam int FLG_DC = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_OV = 3;
   localparam int FLG_N = 4;
   // ------------------------------------------------------------
   // Table pointer modes
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      TPM_HOLD = 2'b00,
      TPM_POSTINC = 2'b01,
      TPM_POSTDEC = 2'b10,
      TPM_PREINC = 2'b11
   } ood_tpm_e;
endpackage

// ===== bench/ood_decode_test.sv
// Self-checking bench for the operand-field decoder over AHB-Lite
`timescale 1ns/100ps
module ood_decode_test;
   import ood_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
   logic hreadyout, hresp, dest_file, shadow_use;
   logic [11:0] file_addr;
   logic [7:0] bit_mask;
   logic [20:0] tptr, p;
   int failures = 0, compares = 0, cycles = 0;
   ood_decode ood_decode_inst (.CLK_I(clk), .RESET_N_I(rst_n), .HSEL_I(hsel),
      .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'b010),
      .HWDATA_I(hwdata), .HREADY_I(hreadyout), .HRDATA_O(hrdata),
      .HREADYOUT_O(hreadyout), .HRESP_O(hresp), .FILE_ADDR_O(file_addr),
      .DEST_FILE_O(dest_file), .BIT_MASK_O(bit_mask), .SHADOW_USE_O(shadow_use),
      .TABLE_POINTER_O(tptr));
   initial
   begin
      forever #25 clk = ~clk;
   end
   // Hang guard, well above the few hundred cycles the tests need
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         tally_and_finish();
      end
   end
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Drives at the next rising edge; returns at the edge that ends the data phase
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h00_0000, a};
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wr ? d : hwdata;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(nm, exp, rd);
   endtask
   // Decode outputs trail the instruction register by one clock
   task automatic settle();
      @(posedge clk);
      #1;
   endtask
   task automatic two(input logic [15:0] i1, input logic [15:0] i2, input logic [7:0] a,
                      input logic [31:0] exp);
      wr(ADDR_INSTR, {16'h0000, i1});
      wr(ADDR_INSTR2, {16'h0000, i2});
      settle();
      rchk("two_word", a, exp);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial
   begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      settle();
      chk("reset_out", 32'h0000_0001, {21'h00_0000, hresp, bit_mask, shadow_use, hreadyout});
      wr(ADDR_BANK, 32'h0000_0005);
      for (int b = 0; b < 8; b++)
      begin
         wr(ADDR_INSTR, {16'h0000, OPC_BIT_CLEAR, 3'(b), 1'b1, 8'hFF});
         settle();
         chk("bit_mask", 32'(8'h01 << b), {24'h00_0000, bit_mask});
         chk("file_addr", 32'h0000_05FF, {20'h0_0000, file_addr});
      end
      wr(ADDR_INSTR, {16'h0000, OPC_BIT_CLEAR, 3'd3, 1'b0, 8'h00});
      settle();
      chk("access_addr", 32'h0000_0000, {20'h0_0000, file_addr});
      rchk("faddr", ADDR_FADDR, 32'h0000_0000);
      rchk("fields", ADDR_FIELDS, 32'h0000_8680);
      $display("test bit clear done");
      for (int d = 0; d < 2; d++)
      begin
         wr(ADDR_INSTR, {16'h0000, 6'b001001, 1'(d), 1'b1, 8'h10});
         settle();
         chk("dest", 32'(d), {31'h0, dest_file});
         chk("bank_addr", 32'h0000_0510, {20'h0_0000, file_addr});
         chk("mask_off", 32'h0000_0000, {24'h00_0000, bit_mask});
      end
      $display("test destination done");
      two({OPC_MOVE, 12'hFFF}, {OPC_SECOND, 12'h000}, ADDR_MOVE, 32'h0000_0FFF);
      chk("move_src", 32'h0000_0FFF, {20'h0_0000, file_addr});
      two({OPC_MOVE, 12'h123}, {OPC_SECOND, 12'hABC}, ADDR_MOVE, 32'h0ABC_0123);
      $display("test move done");
      for (int k = 0; k < 4; k++)
      begin
         wr(ADDR_INSTR, {16'h0000, k < 2 ? {OPC_CALL, 8'h00} | 16'(k << 8)
            : OPC_RETURN | 16'(k & 1)});
         settle();
         chk("shadow", 32'(k & 1), {31'h0, shadow_use});
      end
      $display("test fast mode done");
      two({OPC_REL_BRA, 11'h7FF}, 16'h0000, ADDR_BRANCH, 32'h001F_FFFF);
      two({OPC_REL_BRA, 11'h400}, 16'h0000, ADDR_BRANCH, 32'h001F_FC00);
      two({OPC_REL_BRA, 11'h3FF}, 16'h0000, ADDR_BRANCH, 32'h0000_03FF);
      two({OPC_CALL, 8'h34}, {OPC_SECOND, 12'h567}, ADDR_BRANCH, 32'h000A_CE68);
      rchk("call_lit", ADDR_LIT, 32'h0025_6734);
      two({OPC_BRANCH_NEG, 8'h80}, 16'h0000, ADDR_BRANCH, 32'h001F_FF80);
      two({OPC_BRANCH_NEG, 8'h7F}, 16'h0000, ADDR_BRANCH, 32'h0000_007F);
      two({OPC_LIT8, 8'hA5}, 16'h0000, ADDR_LIT, 32'h0000_00A5);
      two({OPC_LFSR, 8'h0A}, 16'hF0BC, ADDR_LIT, 32'h0010_0ABC);
      $display("test branch and literal done");
      p = 21'h1F_FFFF;
      wr(ADDR_TABLE, {11'h000, p});
      for (int m = 0; m < 4; m++)
      begin
         wr(ADDR_INSTR, {16'h0000, OPC_TABLE, 2'(m)});
         wr(ADDR_TABLE, {24'h80_0000, 8'h5A + 8'(m)});
         p = (m == 0) ? p : (m == 2) ? p - 21'h1 : p + 21'h1;
         settle();
         chk("tptr_port", {11'h000, p}, {11'h000, tptr});
         rchk("table", ADDR_TABLE, {8'h5A + 8'(m), 3'b000, p});
      end
      $display("test table done");
      wr(ADDR_STATUS, 32'hFFFF_FFFF);
      rchk("status", ADDR_STATUS, 32'h0000_001F);
      wr(ADDR_STATUS, 32'h0000_000A);
      rchk("status", ADDR_STATUS, 32'h0000_000A);
      wr(8'h40, 32'hFFFF_FFFF);
      rchk("unmapped", 8'h40, 32'h0000_0000);
      chk("hresp", 32'h0000_0000, {31'h0, hresp});
      $display("test status done");
      tally_and_finish();
   end
endmodule // ood_decode_test
